// ### verilog/kms_key_scan.sv
`timescale 1ns/1ps
`include "kms_params.svh"

// Summary of operation
// - Idle drives all scan lines, key raises event.
// - After the event, scan finds the key number.
// - Two detections 30 ms apart must match.
// - Single key shown in binary on five LEDs.
// - Several keys together light all five LEDs.
// - No key: LEDs off, all lines active, idle.
// - Interval timer paces detections every 30 ms.
// - LED pins carry bits 0 to 4.
// - Scan lines are outputs, key event enabled.
// - Reset: LED pins high, other outputs low.
// - Four return lines sampled together per line.
// - Low-power wait 30 ms between detections.
// - Matrix is four lines by four returns.
module kms_key_scan #(
  parameter int INTERVAL_CYCLES = `KMS_SCAN_INTERVAL_CYCLES,
  parameter int SETTLE_CYCLES = `KMS_SETTLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`KMS_LINES-1:0] keyReturnN,
  output logic [`KMS_LINES-1:0] scanOutN,
  output logic ledBit0Pin,
  output logic ledBit1Pin,
  output logic ledBit2Pin,
  output logic ledBit3Pin,
  output logic ledBit4Pin,
  output logic keyPressEvent,
  output logic scanIntervalEvent,
  output logic lowPowerWait
);

  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  // ========================================================================
  // Helpers
  // ========================================================================

  // Scan pattern that drives one line low and leaves the rest high.
  function automatic logic [`KMS_LINES-1:0] lineDrive(input logic [1:0] l);
    lineDrive = ~(4'h1 << l);
  endfunction : lineDrive

  // ========================================================================
  // State
  // ========================================================================

  kms_pkg::kms_state_t state_q, state_d;  // Controller state.
  logic [1:0] line_q, line_d;             // Scan line being driven.
  logic [SW-1:0] settle_q, settle_d;      // Settle cycles on this line.
  logic [1:0] hits_q, hits_d;             // Closed keys seen, saturating.
  logic [4:0] code_q, code_d;             // Result of the scan in progress.
  logic [4:0] prevCode_q, prevCode_d;     // Result of the previous scan.
  logic havePrev_q, havePrev_d;           // A previous result exists.
  logic [`KMS_LINES-1:0] scanOut_q, scanOut_d;  // Scan pin levels.
  logic [4:0] led_q, led_d;               // LED pin levels, low is lit.
  logic keyEvent_q, keyEvent_d;           // Key press event pulse.
  logic lowPower_q, lowPower_d;           // Waiting between detections.
  logic timerStart;                       // Starts the interval timer.
  logic intervalTick;                     // Timer expiry pulse.

  // Interval timer that paces the second and later detections.
  kms_interval_timer #(
    .CYCLES(INTERVAL_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(timerStart),
    .tick(intervalTick)
  );

  // ========================================================================
  // Controller next-state logic
  // ========================================================================

  // One pass visits the four lines; the return lines are read only after
  // the settle count, since a line just switched may not have settled.
  always_comb begin
    logic [1:0] hitsT;
    logic [4:0] codeT;
    hitsT = hits_q;
    codeT = code_q;
    state_d = state_q;
    line_d = line_q;
    settle_d = settle_q;
    hits_d = hits_q;
    code_d = code_q;
    prevCode_d = prevCode_q;
    havePrev_d = havePrev_q;
    scanOut_d = scanOut_q;
    led_d = led_q;
    keyEvent_d = 1'b0;
    timerStart = 1'b0;
    unique case (state_q)
      kms_pkg::KMS_IDLE: begin
        // All lines active so that any key pulls a return line low.
        scanOut_d = `KMS_SCAN_ALL_ACTIVE;
        if (keyReturnN != `KMS_RETURN_NONE) begin
          keyEvent_d = 1'b1;
          state_d = kms_pkg::KMS_SCAN;
          line_d = 2'h0;
          settle_d = '0;
          hits_d = 2'h0;
          code_d = `KMS_CODE_NONE;
          scanOut_d = lineDrive(2'h0);
        end
      end
      kms_pkg::KMS_SCAN: begin
        if (settle_q != SW'(SETTLE_CYCLES - 1)) begin
          settle_d = settle_q + 1'b1;
        end else begin
          settle_d = '0;
          // All four returns are taken in the same cycle.
          for (int i = 0; i < `KMS_LINES; i++) begin
            if (!keyReturnN[i]) begin
              codeT = {1'b0, line_q, 2'(i)} + 5'h01;
              hitsT = (hitsT == 2'h2) ? 2'h2 : hitsT + 2'h1;
            end
          end
          if (hitsT == 2'h2) begin
            codeT = `KMS_CODE_MULTI;
          end
          if (line_q != 2'h3) begin
            line_d = line_q + 2'h1;
            scanOut_d = lineDrive(line_q + 2'h1);
            hits_d = hitsT;
            code_d = codeT;
          end else if (hitsT == 2'h0) begin
            // Released: dark LEDs, lines back to active, wait for keys.
            state_d = kms_pkg::KMS_IDLE;
            led_d = `KMS_LED_ALL_OFF;
            havePrev_d = 1'b0;
            scanOut_d = `KMS_SCAN_ALL_ACTIVE;
          end else begin
            // A result is shown only when it repeats across the interval;
            // a mismatch leaves the display as it was.
            if (havePrev_q && codeT == prevCode_q) begin
              led_d = ~codeT;
            end
            prevCode_d = codeT;
            havePrev_d = 1'b1;
            state_d = kms_pkg::KMS_WAIT;
            timerStart = 1'b1;
            scanOut_d = `KMS_SCAN_ALL_ACTIVE;
          end
        end
      end
      kms_pkg::KMS_WAIT: begin
        // Resume scanning only on the interval event.
        if (intervalTick) begin
          state_d = kms_pkg::KMS_SCAN;
          line_d = 2'h0;
          settle_d = '0;
          hits_d = 2'h0;
          code_d = `KMS_CODE_NONE;
          scanOut_d = lineDrive(2'h0);
        end
      end
    endcase
    lowPower_d = (state_d == kms_pkg::KMS_WAIT);
  end

  // ========================================================================
  // Controller registers
  // ========================================================================

  // Reset leaves the LED pins high (dark) and the scan pins low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= kms_pkg::KMS_IDLE;
      line_q <= 2'h0;
      settle_q <= '0;
      hits_q <= 2'h0;
      code_q <= `KMS_CODE_NONE;
      prevCode_q <= `KMS_CODE_NONE;
      havePrev_q <= 1'b0;
      scanOut_q <= `KMS_SCAN_ALL_ACTIVE;
      led_q <= `KMS_LED_ALL_OFF;
      keyEvent_q <= 1'b0;
      lowPower_q <= 1'b0;
    end else begin
      state_q <= state_d;
      line_q <= line_d;
      settle_q <= settle_d;
      hits_q <= hits_d;
      code_q <= code_d;
      prevCode_q <= prevCode_d;
      havePrev_q <= havePrev_d;
      scanOut_q <= scanOut_d;
      led_q <= led_d;
      keyEvent_q <= keyEvent_d;
      lowPower_q <= lowPower_d;
    end
  end

  // Outputs come straight from the registers.
  assign scanOutN = scanOut_q;
  assign ledBit0Pin = led_q[0];
  assign ledBit1Pin = led_q[1];
  assign ledBit2Pin = led_q[2];
  assign ledBit3Pin = led_q[3];
  assign ledBit4Pin = led_q[4];
  assign keyPressEvent = keyEvent_q;
  assign scanIntervalEvent = intervalTick;
  assign lowPowerWait = lowPower_q;

  // ========================================================================
  // Checks
  // ========================================================================

  sequence s_scan_done_none;
    state_q == kms_pkg::KMS_SCAN ##1 state_q == kms_pkg::KMS_IDLE;
  endsequence

  sequence s_wake;
    state_q == kms_pkg::KMS_WAIT && intervalTick;
  endsequence

  property p_idle_all_active;
    @(posedge sys_clk) disable iff (rst)
    state_q == kms_pkg::KMS_IDLE && $past(state_q) == kms_pkg::KMS_IDLE
      |-> scanOutN == `KMS_SCAN_ALL_ACTIVE;
  endproperty
  a_idle_all_active: assert property (p_idle_all_active)
    else $error("Idle scan lines not all active.");

  property p_event_starts_scan;
    @(posedge sys_clk) disable iff (rst)
    state_q == kms_pkg::KMS_IDLE && keyReturnN != `KMS_RETURN_NONE
      |=> keyPressEvent && state_q == kms_pkg::KMS_SCAN
          && scanOutN == 4'hE;
  endproperty
  a_event_starts_scan: assert property (p_event_starts_scan)
    else $error("Key press did not start a scan at line 0.");

  property p_one_line_scanned;
    @(posedge sys_clk) disable iff (rst)
    state_q == kms_pkg::KMS_SCAN |-> $countones(~scanOutN) == 1;
  endproperty
  a_one_line_scanned: assert property (p_one_line_scanned)
    else $error("Scan does not drive exactly one line.");

  property p_wake_to_scan;
    @(posedge sys_clk) disable iff (rst)
    s_wake |=> state_q == kms_pkg::KMS_SCAN && !lowPowerWait;
  endproperty
  a_wake_to_scan: assert property (p_wake_to_scan)
    else $error("Interval event did not resume scanning.");

  property p_wait_holds;
    @(posedge sys_clk) disable iff (rst)
    lowPowerWait && !intervalTick |=> lowPowerWait;
  endproperty
  a_wait_holds: assert property (p_wait_holds)
    else $error("Left the low-power wait without the interval event.");

  property p_none_clears;
    @(posedge sys_clk) disable iff (rst)
    s_scan_done_none |-> led_q == `KMS_LED_ALL_OFF
      && scanOutN == `KMS_SCAN_ALL_ACTIVE;
  endproperty
  a_none_clears: assert property (p_none_clears)
    else $error("Release did not clear LEDs and activate all lines.");

  // A new lit pattern must equal the reference stored before this scan,
  // so a single detection can never reach the display.
  property p_show_needs_match;
    @(posedge sys_clk) disable iff (rst)
    led_q != $past(led_q) && led_q != `KMS_LED_ALL_OFF
      |-> $past(havePrev_q) && led_q == ~$past(prevCode_q);
  endproperty
  a_show_needs_match: assert property (p_show_needs_match)
    else $error("LEDs changed without two matching detections.");

  property p_multi_all_on;
    @(posedge sys_clk) disable iff (rst)
    led_q != $past(led_q) && prevCode_q == `KMS_CODE_MULTI
      && led_q != `KMS_LED_ALL_OFF |-> led_q == 5'h00;
  endproperty
  a_multi_all_on: assert property (p_multi_all_on)
    else $error("Several keys did not light every LED.");

endmodule : kms_key_scan

// ### include/kms_params.svh
`ifndef KMS_PARAMS_SVH
`define KMS_PARAMS_SVH

// ==========================================================================
// Timing
// ==========================================================================

// System clock rate in hertz (20 MHz, 50 ns period).
`define KMS_CLK_HZ 20000000
// Spacing between the two key detections, in milliseconds.
`define KMS_SCAN_INTERVAL_MS 30
// Spacing between detections in clock cycles, derived from the figures above.
`define KMS_SCAN_INTERVAL_CYCLES \
  ((`KMS_SCAN_INTERVAL_MS * `KMS_CLK_HZ) / 1000)
// Cycles a scan line is held before the return lines are sampled.
`define KMS_SETTLE_CYCLES 4

// ==========================================================================
// Matrix geometry and pin levels
// ==========================================================================

// Number of scan lines and of return lines.
`define KMS_LINES 4
// Scan pattern with every line driven active (low).
`define KMS_SCAN_ALL_ACTIVE 4'h0
// Return value with no key closed (all lines pulled high).
`define KMS_RETURN_NONE 4'hF
// LED pin levels with every LED dark (LEDs light on a low pin).
`define KMS_LED_ALL_OFF 5'h1F
// Result code meaning that no key is closed.
`define KMS_CODE_NONE 5'h00
// Result code meaning that several keys are closed.
`define KMS_CODE_MULTI 5'h1F

`endif

// ### include/kms_pkg.sv
// ==========================================================================
// Shared types of the key matrix scanner
// ==========================================================================
package kms_pkg;

  // Controller states: key wait, matrix scan, paced wait between scans.
  typedef enum logic [1:0] {
    KMS_IDLE,
    KMS_SCAN,
    KMS_WAIT
  } kms_state_t;

endpackage : kms_pkg

// ### verilog/kms_interval_timer.sv
`timescale 1ns/1ps
`include "kms_params.svh"

// ==========================================================================
// One-shot interval timer pacing the key detections
// ==========================================================================
module kms_interval_timer #(
  parameter int CYCLES = `KMS_SCAN_INTERVAL_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  output logic tick
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q, cnt_d;   // Cycles left before the tick.
  logic run_q, run_d;            // Timer is counting.
  logic tick_q, tick_d;          // Registered tick pulse.

  // Next-state logic: a start reloads, so the tick lands CYCLES cycles
  // after the start cycle; CYCLES must be at least two.
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    tick_d = 1'b0;
    if (start) begin
      cnt_d = CW'(CYCLES - 2);
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        tick_d = 1'b1;
        run_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  // State registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

  // Helper: cycles elapsed since the last start, for the check below.
  logic [CW:0] elapsed_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      elapsed_q <= '0;
    end else if (start) begin
      elapsed_q <= (CW + 1)'(1);
    end else if (run_q) begin
      elapsed_q <= elapsed_q + 1'b1;
    end
  end

  // The tick comes exactly one interval after its start.
  property p_interval_exact;
    @(posedge sys_clk) disable iff (rst)
    tick |-> elapsed_q == (CW + 1)'(CYCLES);
  endproperty
  a_interval_exact: assert property (p_interval_exact)
    else $error("Interval tick not one period after start.");

endmodule : kms_interval_timer

// ### verification/kms_key_matrix.sv
`timescale 1ns/1ps

// ==========================================================================
// Key matrix model: sixteen switches with series diodes and pull-ups
// ==========================================================================
module kms_key_matrix (
  input wire logic [3:0] scanOutN,
  input wire logic [15:0] keysDown,
  output logic [3:0] keyReturnN
);
  // A return line idles high on its pull-up, never at the last value.
  // A closed key pulls it low only while its scan line is driven low.
  // The diodes keep two driven lines from fighting through a key pair.
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      keyReturnN[r] = 1'b1;
      for (int l = 0; l < 4; l++) begin
        if (keysDown[l*4+r] && !scanOutN[l]) begin
          keyReturnN[r] = 1'b0;
        end
      end
    end
  end
endmodule : kms_key_matrix

// ### verification/kms_key_scan_tb.sv
`timescale 1ns/1ps

// ==========================================================================
// Self-checking bench for the key matrix scanner
// ==========================================================================
module kms_key_scan_tb;
  // Short interval keeps the run small; the interval expectations derive from it.
  localparam int INTERVAL = 40;
  localparam int SETTLE = 4;
  localparam int SCAN = 4 * SETTLE + 4;

  logic sys_clk; // System clock.
  logic rst; // Synchronous reset.
  logic [15:0] keysDown; // Keys held by the bench, index line*4+return.
  logic [3:0] keyReturnN; // Return lines from the matrix model.
  logic [3:0] scanOutN; // Scan lines from the scanner.
  logic ledBit0Pin, ledBit1Pin, ledBit2Pin, ledBit3Pin, ledBit4Pin;
  logic keyPressEvent, scanIntervalEvent, lowPowerWait;
  logic [4:0] ledPins; // LED pins gathered as one number.
  int errors; // Mismatches seen.
  int n_compared; // Comparisons made.

  // Bit i of the number sits on LED pin i.
  assign ledPins = {ledBit4Pin, ledBit3Pin, ledBit2Pin, ledBit1Pin,
    ledBit0Pin};

  kms_key_scan #(.INTERVAL_CYCLES(INTERVAL), .SETTLE_CYCLES(SETTLE))
    u_kms_key_scan (.sys_clk(sys_clk), .rst(rst), .keyReturnN(keyReturnN),
    .scanOutN(scanOutN), .ledBit0Pin(ledBit0Pin), .ledBit1Pin(ledBit1Pin),
    .ledBit2Pin(ledBit2Pin), .ledBit3Pin(ledBit3Pin),
    .ledBit4Pin(ledBit4Pin), .keyPressEvent(keyPressEvent),
    .scanIntervalEvent(scanIntervalEvent), .lowPowerWait(lowPowerWait));

  kms_key_matrix u_kms_key_matrix (.scanOutN(scanOutN),
    .keysDown(keysDown), .keyReturnN(keyReturnN));

  // Clock of 50 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ========================================================================
  // Helpers
  // ========================================================================

  // Step one cycle and land just after the edge, where outputs settled.
  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask : tick

  // Prints the verdict and stops; the only place the run ends.
  task automatic end_sim();
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // Compares with case equality so an unknown never passes.
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Conditions that the bounded wait can look for.
  function automatic logic hit(input int sel);
    case (sel)
      0: hit = (keyPressEvent === 1'b1);
      1: hit = (scanIntervalEvent === 1'b1);
      2: hit = (lowPowerWait === 1'b1);
      4: hit = (scanOutN === 4'hD);
      5: hit = (scanOutN === 4'hB);
      6: hit = (scanOutN === 4'h7);
      default: hit = (scanOutN === 4'h0 && lowPowerWait === 1'b0);
    endcase
  endfunction : hit

  // Waits at most lim+1 cycles; n returns the cycles spent.
  task automatic waitc(input int sel, input int lim, input string nm,
    output int n);
    n = 0;
    while (!hit(sel) && n <= lim) begin
      tick();
      n++;
    end
    n_compared++;
    if (!hit(sel)) begin
      errors++;
      $display("mismatch %s expected 1 seen 0", nm);
    end
  endtask : waitc

  // ========================================================================
  // Scenario steps
  // ========================================================================

  // Presses keys from idle and follows the first scan into the wait.
  task automatic start(input logic [15:0] mask, input logic [4:0] prev);
    int n;
    keysDown = mask;
    waitc(0, 4, "keyPressEvent", n);
    chk("first scan line", 8'hE, {4'h0, scanOutN});
    for (int i = 4; i < 7; i++) begin
      waitc(i, SETTLE, "next scan line", n);
      chk("scan line hold", 8'(SETTLE), n[7:0]);
    end
    waitc(2, SETTLE + 1, "lowPowerWait", n);
    chk("lines in wait", 8'h0, {4'h0, scanOutN});
    chk("leds before confirm", {3'h0, prev}, {3'h0, ledPins});
  endtask : start

  // Waits out one interval, rescans and checks the display.
  task automatic pass(input logic [4:0] expLed);
    int n;
    waitc(1, INTERVAL, "scanIntervalEvent", n);
    chk("interval length", 8'(INTERVAL - 1), n[7:0]);
    tick();
    waitc(2, SCAN, "second scan", n);
    chk("leds after scan", {3'h0, expLed}, {3'h0, ledPins});
  endtask : pass

  // Lets go of every key; the next scan must fall back to idle.
  task automatic let_go();
    int n;
    keysDown = 16'h0000;
    waitc(1, INTERVAL, "scanIntervalEvent", n);
    tick();
    waitc(7, SCAN, "return to idle", n);
    chk("leds off", 8'h1F, {3'h0, ledPins});
    repeat (3) tick();
    chk("idle lines", 8'h0, {4'h0, scanOutN});
  endtask : let_go

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    rst = 1'b1;
    keysDown = 16'h0000;
    errors = 0;
    n_compared = 0;
    repeat (16) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    chk("reset lines", 8'h0, {4'h0, scanOutN});
    chk("reset leds", 8'h1F, {3'h0, ledPins});
    chk("reset wait", 8'h0, {7'h0, lowPowerWait});
    // Every key in turn; the number is line times four plus return plus one.
    for (int k = 0; k < 16; k++) begin
      start(16'h0001 << k, 5'h1F);
      pass(~5'(k + 1));
      let_go();
    end
    // Two keys on different lines, then two on the same line.
    start(16'h8001, 5'h1F);
    pass(5'h00);
    let_go();
    start(16'h0003, 5'h1F);
    pass(5'h00);
    let_go();
    // Bouncing contact: the two results differ, so the display must hold.
    start(16'h0004, 5'h1F);
    keysDown = 16'h0010;
    pass(5'h1F);
    pass(~5'h05);
    let_go();
    end_sim();
  end

  // Watchdog well beyond the expected few thousand cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("mismatch watchdog expected done seen hang");
    end_sim();
  end
endmodule : kms_key_scan_tb
